// >>> mpt_pkg.sv
package mpt_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] MPT_ADDR_PIN_CONFIG = 8'h00;
	localparam logic [7:0] MPT_ADDR_SW_TRIGGER = 8'h04;
	localparam logic [7:0] MPT_ADDR_STATE = 8'h08;
	localparam logic [7:0] MPT_ADDR_NVM_CONFIG = 8'h0C;

	// ----------------------------------------------------------------
	// field positions in the pin configuration word
	// ----------------------------------------------------------------
	localparam int MPT_POS_INPUT_SELECT = 0;
	localparam int MPT_POS_FUNC = 1;
	localparam int MPT_POS_MASK = 5;
	localparam int MPT_POS_OUTPUT_SELECT = 13;
	localparam int MPT_POS_SYNC = 16;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [3:0] MPT_FUNC_RESET = 4'h0;
	localparam logic [1:0] MPT_MASK_RESET = 2'h0;
	localparam int MPT_CHANNELS = 2;
	localparam logic [3:0] MPT_BOOT_WAIT = 4'h3;

	// ----------------------------------------------------------------
	// input function codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MPT_FN_NONE = 4'b0000,
		MPT_FN_SNAPSHOT = 4'b0010,
		MPT_FN_CUR_PWR = 4'b0011,
		MPT_FN_VOLT_PWR = 4'b0100,
		MPT_FN_PROTECT = 4'b0101,
		MPT_FN_CLEAR = 4'b0111,
		MPT_FN_LOAD = 4'b1000,
		MPT_FN_WAVE = 4'b1001,
		MPT_FN_MARGIN = 4'b1010,
		MPT_FN_RESET = 4'b1011,
		MPT_FN_PROG_LOCK = 4'b1100,
		MPT_FN_WRITE_LOCK = 4'b1101
	} mpt_func_type;

	// per-channel action pulses travel together
	typedef struct packed {
		logic [1:0] curDown;
		logic [1:0] curUp;
		logic [1:0] voltDown;
		logic [1:0] voltUp;
		logic [1:0] load;
		logic [1:0] waveStop;
		logic [1:0] waveStart;
		logic [1:0] marginLow;
		logic [1:0] marginHigh;
	} mpt_chan_act_type;

	// global action pulses
	typedef struct packed {
		logic snapshot;
		logic protect;
		logic clear;
		logic devReset;
	} mpt_glob_act_type;

	// boot sequencing
	typedef enum logic [1:0] {
		MPT_ST_LOAD = 2'b00,
		MPT_ST_WAIT = 2'b01,
		MPT_ST_SAMPLE = 2'b10,
		MPT_ST_RUN = 2'b11
	} mpt_state_type;

endpackage

// >>> mpt_pin_map.sv
`timescale 1ns/1ns

// What this block does
// - input select bit makes the pin an input, output select bit an output if input select is clear.
// - pin-triggered per-channel actions apply only to channels set in the trigger mask.
// - snapshot, protect, clear codes fire on falling edge; rising ignored.
// - current power, waveform, margin codes act on both edges per channel.
// - voltage power-down uses the configured pulldown; rising powers up.
// - load code fires on falling edge for masked channels with sync set.
// - reset code resets the device on a complete low pulse only.
// - programming lock and write lock follow falling and rising edges.
// - write lock still admits unlock key and reset field writes.
// - after boot the pin level is sampled once and its command run.
// - after reset with defaults the pin triggers nothing.
// - a mapped input function other than reset masks the matching software trigger.
// - software constraints also gate pin-triggered actions.
// - pin configuration loads from nonvolatile image at boot.
module mpt_pin_map
	import mpt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] nvmImage,
	input wire logic [1:0] syncSelect,
	input wire logic [1:0] voltPulldownSel,
	input wire logic protectAllowed,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOutEn_n,
	input wire logic statusOut,
	output mpt_chan_act_type chanAct,
	output mpt_glob_act_type globAct,
	output logic [1:0] voltPulldownUsed,
	output logic progAllowed,
	output logic writeAllowed,
	output logic bootDone
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic inputSelect_reg;
	logic outputSelect_reg;
	logic [3:0] funcCode_reg;
	logic [1:0] chanMask_reg;
	logic sync1_reg;
	logic sync2_reg;
	logic pinLast_reg;
	logic pulseLow_reg;
	logic [3:0] bootCnt_reg;
	mpt_state_type state_reg;
	mpt_chan_act_type chanAct_next;
	mpt_glob_act_type globAct_next;
	logic fallEdge;
	logic riseEdge;
	logic inMode;
	logic bootSample;
	logic doFall;
	logic doRise;
	logic [1:0] loadMask;
	logic apbWrite;
	logic apbAccess;
	logic decodeOk;
	logic swLockWrite;
	logic [31:0] cfgWord;

	// ----------------------------------------------------------------
	// pin synchroniser and edge detect
	// ----------------------------------------------------------------
	// first stage is read only by the second
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			pinLast_reg <= 1'b1;
		end else begin
			sync1_reg <= pinIn;
			sync2_reg <= sync1_reg;
			pinLast_reg <= sync2_reg;
		end
	end

	assign fallEdge = pinLast_reg & ~sync2_reg;
	assign riseEdge = ~pinLast_reg & sync2_reg;
	// edges are ignored until the boot sample has run
	assign inMode = inputSelect_reg & (state_reg == MPT_ST_RUN);
	assign bootSample = (state_reg == MPT_ST_SAMPLE) & inputSelect_reg;
	// a boot level acts like the edge that would have led to it
	assign doFall = (inMode & fallEdge) | (bootSample & ~sync2_reg);
	assign doRise = (inMode & riseEdge) | (bootSample & sync2_reg);
	assign loadMask = chanMask_reg & syncSelect;

	// ----------------------------------------------------------------
	// boot sequencing: load image, let synchroniser settle, sample once
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= MPT_ST_LOAD;
			bootCnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				MPT_ST_LOAD: begin
					state_reg <= MPT_ST_WAIT;
				end
				MPT_ST_WAIT: begin
					bootCnt_reg <= bootCnt_reg + 4'h1;
					if (bootCnt_reg == MPT_BOOT_WAIT) begin
						state_reg <= MPT_ST_SAMPLE;
					end
				end
				MPT_ST_SAMPLE: begin
					state_reg <= MPT_ST_RUN;
				end
				MPT_ST_RUN: begin
					state_reg <= MPT_ST_RUN;
				end
				default: begin
					state_reg <= MPT_ST_LOAD;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// apb slave: zero wait states, unmapped addresses answer with error
	// ----------------------------------------------------------------
	assign apbAccess = psel & penable;
	assign apbWrite = apbAccess & pwrite & decodeOk; // unmapped writes must not alias a register
	assign decodeOk = (paddr[31:0] == {24'h0000_00, MPT_ADDR_PIN_CONFIG})
		| (paddr[31:0] == {24'h0000_00, MPT_ADDR_SW_TRIGGER})
		| (paddr[31:0] == {24'h0000_00, MPT_ADDR_STATE})
		| (paddr[31:0] == {24'h0000_00, MPT_ADDR_NVM_CONFIG});
	// write lock stops config writes; only the trigger word keeps unlock/reset
	assign swLockWrite = ~writeAllowed & (paddr[7:0] == MPT_ADDR_PIN_CONFIG);

	assign cfgWord = {14'h0000, syncSelect, 2'h0, outputSelect_reg, 6'h00, chanMask_reg,
		funcCode_reg, inputSelect_reg};

	// configuration register, loaded from the nonvolatile image at boot
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			inputSelect_reg <= 1'b0;
			outputSelect_reg <= 1'b0;
			funcCode_reg <= MPT_FUNC_RESET;
			chanMask_reg <= MPT_MASK_RESET;
		end else if (state_reg == MPT_ST_LOAD) begin
			inputSelect_reg <= nvmImage[MPT_POS_INPUT_SELECT];
			outputSelect_reg <= nvmImage[MPT_POS_OUTPUT_SELECT];
			funcCode_reg <= nvmImage[MPT_POS_FUNC +: 4];
			chanMask_reg <= nvmImage[MPT_POS_MASK +: 2];
		end else if (apbWrite & (paddr[7:0] == MPT_ADDR_PIN_CONFIG) & ~swLockWrite) begin
			inputSelect_reg <= pwdata[MPT_POS_INPUT_SELECT];
			outputSelect_reg <= pwdata[MPT_POS_OUTPUT_SELECT];
			funcCode_reg <= pwdata[MPT_POS_FUNC +: 4];
			chanMask_reg <= pwdata[MPT_POS_MASK +: 2];
		end
	end

	// bus answer
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~decodeOk;
			prdata <= 32'h0000_0000;
			if (psel & ~penable & ~pwrite & decodeOk) begin
				case (paddr[7:0])
					MPT_ADDR_PIN_CONFIG: prdata <= cfgWord;
					MPT_ADDR_STATE: prdata <= {26'h000_0000, bootDone, progAllowed,
						writeAllowed, sync2_reg, state_reg};
					MPT_ADDR_NVM_CONFIG: prdata <= nvmImage;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// dispatch of pin and software triggers
	// ----------------------------------------------------------------
	always_comb begin
		chanAct_next = '0;
		globAct_next = '0;
		case (funcCode_reg)
			MPT_FN_SNAPSHOT: globAct_next.snapshot = doFall;
			MPT_FN_PROTECT: globAct_next.protect = doFall & protectAllowed;
			MPT_FN_CLEAR: globAct_next.clear = doFall;
			MPT_FN_CUR_PWR: begin
				chanAct_next.curDown = {2{doFall}} & chanMask_reg;
				chanAct_next.curUp = {2{doRise}} & chanMask_reg;
			end
			MPT_FN_VOLT_PWR: begin
				chanAct_next.voltDown = {2{doFall}} & chanMask_reg;
				chanAct_next.voltUp = {2{doRise}} & chanMask_reg;
			end
			MPT_FN_LOAD: chanAct_next.load = {2{doFall}} & loadMask;
			MPT_FN_WAVE: begin
				chanAct_next.waveStop = {2{doFall}} & chanMask_reg;
				chanAct_next.waveStart = {2{doRise}} & chanMask_reg;
			end
			MPT_FN_MARGIN: begin
				chanAct_next.marginLow = {2{doFall}} & chanMask_reg;
				chanAct_next.marginHigh = {2{doRise}} & chanMask_reg;
			end
			// reset fires on the rise that ends a low seen in run mode
			MPT_FN_RESET: globAct_next.devReset = inMode & riseEdge & pulseLow_reg;
			default: begin
				chanAct_next = '0;
				globAct_next = '0;
			end
		endcase
		// software triggers other than reset, ignored when the pin owns the same function
		if (apbWrite & (paddr[7:0] == MPT_ADDR_SW_TRIGGER)) begin
			// trigger bits obey the write lock; only reset and unlock bypass it
			if (writeAllowed && !(inputSelect_reg && funcCode_reg == MPT_FN_SNAPSHOT)) begin
				globAct_next.snapshot = globAct_next.snapshot | pwdata[0];
			end
			if (writeAllowed && !(inputSelect_reg && funcCode_reg == MPT_FN_PROTECT)) begin
				globAct_next.protect = globAct_next.protect | (pwdata[1] & protectAllowed);
			end
			if (writeAllowed && !(inputSelect_reg && funcCode_reg == MPT_FN_CLEAR)) begin
				globAct_next.clear = globAct_next.clear | pwdata[2];
			end
			if (writeAllowed && !(inputSelect_reg && funcCode_reg == MPT_FN_LOAD)) begin
				chanAct_next.load = chanAct_next.load | (pwdata[5:4] & syncSelect);
			end
			// reset field is honoured even under the write lock
			globAct_next.devReset = globAct_next.devReset | pwdata[3];
		end
	end

	// low pulse tracker for the reset function
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pulseLow_reg <= 1'b0;
		end else if (inMode & fallEdge) begin
			pulseLow_reg <= 1'b1;
		end else if (riseEdge) begin
			pulseLow_reg <= 1'b0;
		end
	end

	// registered action outputs, one cycle pulses
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			chanAct <= '0;
			globAct <= '0;
			voltPulldownUsed <= 2'h0;
		end else begin
			chanAct <= chanAct_next;
			globAct <= globAct_next;
			voltPulldownUsed <= voltPulldownSel;
		end
	end

	// lock levels; the unlock key in the trigger word reopens writes
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			progAllowed <= 1'b1;
			writeAllowed <= 1'b1;
		end else begin
			if (funcCode_reg == MPT_FN_PROG_LOCK) begin
				if (doFall) progAllowed <= 1'b1;
				else if (doRise) progAllowed <= 1'b0;
			end
			if (funcCode_reg == MPT_FN_WRITE_LOCK) begin
				if (doFall) writeAllowed <= 1'b1;
				else if (doRise) writeAllowed <= 1'b0;
			end
			if (apbWrite & (paddr[7:0] == MPT_ADDR_SW_TRIGGER) & pwdata[8]) begin
				writeAllowed <= 1'b1;
			end
		end
	end

	// pin output drive and boot flag
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pinOut <= 1'b0;
			pinOutEn_n <= 1'b1;
			bootDone <= 1'b0;
		end else begin
			pinOut <= statusOut;
			pinOutEn_n <= ~(outputSelect_reg & ~inputSelect_reg);
			bootDone <= (state_reg == MPT_ST_RUN);
		end
	end

endmodule

// >>> mpt_pin_map_sva.sv
`timescale 1ns/1ns
module mpt_pin_map_sva
	import mpt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] voltPulldownSel,
	input wire logic [1:0] voltPulldownUsed,
	input wire mpt_chan_act_type chanAct,
	input wire mpt_glob_act_type globAct,
	input wire logic progAllowed,
	input wire logic writeAllowed,
	input wire logic pinOutEn_n,
	input wire logic bootDone
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ----
	// sequences
	// ----
	sequence boot_s;
		!bootDone ##[1:10] bootDone;
	endsequence
	sequence setup_s;
		psel && !penable;
	endsequence
	// boot must finish within ten edges of release
	boot_seq_a: assert property ($fell(reset) |-> boot_s)
		else $error("boot did not complete in time");
	zero_wait_a: assert property (setup_s |=> pready)
		else $error("no answer in the first access cycle");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	err_decode_a: assert property (setup_s |=> pslverr == ($past(paddr) > 32'h0000_000C
		|| $past(paddr[1:0]) != 2'b00))
		else $error("error flag does not match decode");
	// checked through reset itself, so the default disable is overridden
	reset_state_a: assert property (disable iff (1'b0) reset |=> !bootDone && pinOutEn_n
		&& progAllowed && writeAllowed && !(|globAct) && !(|chanAct))
		else $error("outputs not at reset values");
	pulldown_follow_a: assert property (!$past(reset) |-> voltPulldownUsed == $past(voltPulldownSel))
		else $error("pulldown choice not carried");
	opposite_edges_a: assert property ((chanAct.curDown & chanAct.curUp) == 2'b00
		&& (chanAct.marginLow & chanAct.marginHigh) == 2'b00
		&& (chanAct.waveStop & chanAct.waveStart) == 2'b00)
		else $error("both edge actions at once");
	single_pulse_a: assert property ((|chanAct || |globAct) |=> !(|chanAct || |globAct))
		else $error("action pulse longer than one cycle");
endmodule

bind mpt_pin_map mpt_pin_map_sva chk (.clk_sys(clk_sys), .reset(reset), .paddr(paddr),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.voltPulldownSel(voltPulldownSel), .voltPulldownUsed(voltPulldownUsed),
	.chanAct(chanAct), .globAct(globAct), .progAllowed(progAllowed),
	.writeAllowed(writeAllowed), .pinOutEn_n(pinOutEn_n), .bootDone(bootDone));

// >>> mpt_pin_drv.sv
`timescale 1ns/1ns
// ----
// board logic: pulls the pin low on request, after a settable lag
// ----
module mpt_pin_drv (
	input wire logic clk_sys,
	input wire logic wantLow,
	input wire logic [3:0] lag,
	output logic drvEn_n
);
	logic low = 1'b0;
	logic [3:0] cnt = 4'h0;
	// released pin goes to the pull-up, so a low pulse is wantLow held then dropped
	always @(posedge clk_sys) begin
		if (wantLow != low && cnt >= lag) begin
			low <= wantLow;
			cnt <= 4'h0;
		end else if (wantLow != low)
			cnt <= cnt + 4'h1;
		else
			cnt <= 4'h0;
	end
	assign drvEn_n = !low;
endmodule

// >>> mpt_pin_map_test.sv
`timescale 1ns/1ns
module mpt_pin_map_test;
	import mpt_pkg::*;
	typedef struct packed {logic [3:0] fn; logic [1:0] m; logic fall; logic [3:0] hit;} mpt_row_type;
	logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, nvmImage = '0, prdata, rd;
	logic [1:0] syncSelect = 2'b11, voltPulldownSel = 2'b10, voltPulldownUsed;
	logic protectAllowed = 1'b1, statusOut = 1'b0, wantLow = 1'b0, clrAcc = 1'b1;
	logic [3:0] lag = 4'h0;
	logic pready, pslverr, er, drvEn_n, pinOut, pinOutEn_n, pinWire;
	logic progAllowed, writeAllowed, bootDone;
	logic [21:0] acc;
	mpt_chan_act_type chanAct;
	mpt_glob_act_type globAct;
	int n_errors = 0;
	int comparisons = 0;
	// hit: 0..8 channel field, 9..12 global action, 15 nothing
	mpt_row_type rows [0:18] = '{'{4'h2, 2'h0, 1'b1, 4'h9}, '{4'h2, 2'h0, 1'b0, 4'hF},
		'{4'h3, 2'h1, 1'b1, 4'h0}, '{4'h3, 2'h2, 1'b0, 4'h1}, '{4'h4, 2'h3, 1'b1, 4'h2},
		'{4'h4, 2'h1, 1'b0, 4'h3}, '{4'h5, 2'h0, 1'b1, 4'hA}, '{4'h5, 2'h0, 1'b0, 4'hF},
		'{4'h7, 2'h0, 1'b1, 4'hB}, '{4'h7, 2'h0, 1'b0, 4'hF}, '{4'h8, 2'h2, 1'b1, 4'h4},
		'{4'h8, 2'h2, 1'b0, 4'hF}, '{4'h9, 2'h1, 1'b1, 4'h5}, '{4'h9, 2'h3, 1'b0, 4'h6},
		'{4'hA, 2'h2, 1'b1, 4'h7}, '{4'hA, 2'h1, 1'b0, 4'h8}, '{4'h1, 2'h3, 1'b1, 4'hF},
		'{4'hF, 2'h3, 1'b0, 4'hF}, '{4'h0, 2'h3, 1'b1, 4'hF}};
	// ----
	// clock, pin wire, action capture
	// ----
	always #5 clk_sys = ~clk_sys;
	assign pinWire = !pinOutEn_n ? pinOut : drvEn_n; // pull-up wins when nobody drives
	always @(posedge clk_sys) acc <= clrAcc ? '0 : acc | {chanAct, globAct}; // pulses are one cycle
	mpt_pin_map dut (.clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nvmImage(nvmImage), .syncSelect(syncSelect),
		.voltPulldownSel(voltPulldownSel), .protectAllowed(protectAllowed), .pinIn(pinWire),
		.pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .statusOut(statusOut), .chanAct(chanAct),
		.globAct(globAct), .voltPulldownUsed(voltPulldownUsed), .progAllowed(progAllowed),
		.writeAllowed(writeAllowed), .bootDone(bootDone));
	mpt_pin_drv drv (.clk_sys(clk_sys), .wantLow(wantLow), .lag(lag), .drvEn_n(drvEn_n));
	task automatic tally_and_finish();
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one transfer; request held until ready is sampled, then released for a cycle
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int i;
		i = 0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			tally_and_finish();
		end
		tick(1);
	endtask
	task automatic waitBoot();
		int i;
		for (i = 0; i < 30 && bootDone !== 1'b1; i++)
			@(posedge clk_sys);
		if (bootDone !== 1'b1) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	function automatic logic [31:0] cfg(input logic [3:0] fn, input logic [1:0] m, input logic o);
		return {18'h0_0000, o, 6'h00, m, fn, ~o};
	endfunction
	function automatic logic [21:0] expAct(input logic [3:0] h, input logic [1:0] m);
		if (h < 4'h9)
			return 22'(m) << (20 - 2 * h);
		if (h < 4'hD)
			return 22'h00_0001 << (12 - h);
		return '0;
	endfunction
	task automatic clr();
		clrAcc <= 1'b1;
		tick(1);
		clrAcc <= 1'b0;
	endtask
	// settle the pin at the far level, map the code, then make one edge
	task automatic edgeCase(input logic [3:0] fn, input logic [1:0] m, input logic fall);
		wantLow <= !fall;
		tick(8);
		apb(1'b1, 32'h0000_0000, cfg(fn, m, 1'b0));
		clr();
		wantLow <= fall;
		tick(12);
	endtask
	initial begin
		tick(20);
		reset <= 1'b0;
		clrAcc <= 1'b0;
		waitBoot();
		check("idle", {acc, progAllowed, writeAllowed, pinOutEn_n}, 32'h0000_0007);
		apb(1'b0, 32'h0000_0000, '0);
		check("config reset", rd, {14'h0000, syncSelect, 16'h0000});
		foreach (rows[i]) begin
			edgeCase(rows[i].fn, rows[i].m, rows[i].fall);
			check("row", acc, expAct(rows[i].hit, rows[i].m));
		end
		check("pulldown", voltPulldownUsed, voltPulldownSel);
		syncSelect <= 2'b01;
		edgeCase(4'h8, 2'h3, 1'b1);
		check("load sync", acc, expAct(4'h4, 2'h1));
		protectAllowed <= 1'b0;
		edgeCase(4'h5, 2'h0, 1'b1);
		check("protect gated", acc, '0);
		protectAllowed <= 1'b1;
		clr();
		apb(1'b1, 32'h0000_0004, 32'h0000_0002);
		tick(1);
		check("sw masked", acc, '0);
		apb(1'b1, 32'h0000_0000, cfg(4'h2, 2'h0, 1'b0));
		clr();
		apb(1'b1, 32'h0000_0004, 32'h0000_0002);
		tick(1);
		check("sw protect", acc, expAct(4'hA, 2'h0));
		lag <= 4'h3;
		edgeCase(4'hB, 2'h0, 1'b1);
		check("fall only", acc, '0);
		wantLow <= 1'b0;
		tick(14);
		check("low pulse", acc, expAct(4'hC, 2'h0));
		lag <= 4'h0;
		edgeCase(4'hD, 2'h0, 1'b0);
		check("write lock", writeAllowed, 1'b0);
		apb(1'b1, 32'h0000_0000, cfg(4'h0, 2'h0, 1'b0));
		apb(1'b0, 32'h0000_0000, '0);
		check("locked config", rd, cfg(4'hD, 2'h0, 1'b0) | 32'h0001_0000);
		clr();
		apb(1'b1, 32'h0000_0004, 32'h0000_000A);
		tick(1);
		check("reset bypass", acc, expAct(4'hC, 2'h0));
		wantLow <= 1'b1;
		tick(12);
		check("write unlock", writeAllowed, 1'b1);
		wantLow <= 1'b0;
		tick(12);
		check("relock", writeAllowed, 1'b0);
		apb(1'b1, 32'h0000_0004, 32'h0000_0100);
		check("unlock key", writeAllowed, 1'b1);
		edgeCase(4'hC, 2'h0, 1'b0);
		check("prog lock", progAllowed, 1'b0);
		wantLow <= 1'b1;
		tick(12);
		check("prog allow", progAllowed, 1'b1);
		apb(1'b0, 32'h0000_0010, '0);
		check("unmapped", er, 1'b1);
		apb(1'b1, 32'h0000_0100, '0);
		check("alias write", er, 1'b1);
		apb(1'b0, 32'h0000_0000, '0);
		check("alias kept", rd, cfg(4'hC, 2'h0, 1'b0) | 32'h0001_0000);
		wantLow <= 1'b0;
		apb(1'b1, 32'h0000_0000, cfg(4'h0, 2'h0, 1'b1));
		for (int v = 0; v < 2; v++) begin
			statusOut <= v[0];
			tick(4);
			check("pin drive", {pinOutEn_n, pinOut}, {1'b0, v[0]});
		end
		// the pin setting sits in the image so it survives the reset
		nvmImage <= cfg(4'h2, 2'h0, 1'b0);
		wantLow <= 1'b1;
		tick(8);
		reset <= 1'b1;
		clrAcc <= 1'b1;
		tick(3);
		reset <= 1'b0;
		clrAcc <= 1'b0;
		waitBoot();
		tick(2);
		check("boot sample", acc, expAct(4'h9, 2'h0));
		apb(1'b0, 32'h0000_0000, '0);
		check("boot config", rd, cfg(4'h2, 2'h0, 1'b0) | 32'h0001_0000);
		apb(1'b0, 32'h0000_0008, '0);
		check("state", rd, 32'h0000_003B);
		apb(1'b0, 32'h0000_000C, '0);
		check("image", rd, cfg(4'h2, 2'h0, 1'b0));
		tally_and_finish();
	end
endmodule
